// ===== hdl/cmbm_top.sv
// Summary of operation
// - Transmit pin low dominant, high recessive
// - Port bit 0 receives, bit 1 transmits
// - Other six port pins use control, direction
// - Two-stage receive FIFO, host sees foreground
// - Each receive buffer holds 13 bytes
// - Full flag means foreground holds accepted frame
// - Accepted frame copied when flag clear, flag set
// - Background overwritten by every incoming frame, except while it holds an unread accepted frame
// - Both full: drop new frame, flag overrun
// - Own frames only reach background unless loop-back
// - Three transmit buffers with 8-bit priority
// - Schedule pending buffers, set empty on success
// - Lowest priority value wins among pending buffers with no abort request
// - Selection re-run at every arbitration attempt
// - Re-arbitrate right after sending if pending
// - Abort only frames not yet on bus
// - Abort acknowledge tells aborted from sent
// - Instances at 512 and 256 bytes above first
// - Flags cleared by writing one, persist
// - Receive interrupt right after end of frame
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "cmbm_defines.svh"

module cmbm_top
	import cmbm_pkg::*;
#(
	parameter int INSTANCE = 0
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [11:0]  paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic      [31:0]  prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	input  wire logic [7:0]   port_pin_i,
	output logic      [7:0]   port_pin_o,
	output logic      [7:0]   port_oe_n_o,
	output logic              port_pull_o,
	output logic              bus_rx_pin_o,
	input  wire logic         tx_bit_i,
	input  wire cmbm_rx_evt_t rx_evt_i,
	input  wire cmbm_tx_evt_t tx_evt_i,
	output logic              loopback_o,
	output logic              tx_pend_o,
	output logic      [1:0]   tx_idx_o,
	output cmbm_frame_t       tx_frame_o,
	output logic              rx_irq_o,
	output logic              tx_irq_o,
	output logic              err_irq_o
);

	// Window base of this instance
	localparam logic [11:0] INST_BASE = (INSTANCE == 1) ? `CMBM_INST1_OFS :
		(INSTANCE == 2) ? `CMBM_INST2_OFS : 12'h000;

	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        loop_q;
	logic        pull_q;
	logic [7:0]  ddr_q;
	logic [7:0]  pdat_q;
	logic        rxfie_q;
	logic        ovrie_q;
	logic [2:0]  txeie_q;
	logic        rxf_q;
	logic        ovr_q;
	logic        bg_held_q;
	cmbm_frame_t rx_fg_q;
	cmbm_frame_t rx_bg_q;
	logic        txe_q   [`CMBM_NUM_TXB];
	logic        abort_acknowledge_flag_q [`CMBM_NUM_TXB];
	logic        abort_request_flag_q [`CMBM_NUM_TXB];
	logic [7:0]  local_priority_field_q  [`CMBM_NUM_TXB];
	cmbm_frame_t tx_buf_q [`CMBM_NUM_TXB];
	logic [2:0]  txe_v;
	logic [2:0]  abort_acknowledge_flag_v;
	logic [2:0]  abort_request_flag_v;
	cmbm_txst_t  st_q;
	logic [1:0]  act_q;
	cmbm_frame_t tx_frame_q;
	logic        tx_pend_q;
	logic [7:0]  pin_out_q;
	logic [7:0]  oe_n_q;
	logic        bus_rx_q;
	logic        rx_irq_q;
	logic        tx_irq_q;
	logic        err_irq_q;

	logic [7:0]  off;
	logic        inst_hit;
	logic        mapped;
	logic [31:0] rdata_c;
	logic        tx_hit;
	logic [1:0]  tx_b;
	logic [3:0]  tx_w;
	logic [3:0]  rx_w;
	logic        wr_en;
	logic        best_ok;
	logic [1:0]  best_idx;
	logic [7:0]  best_local_priority_field;
	logic        own_frame;
	logic        accepted;
	logic        rxf_clr;

	// ---------------- APB decode and read mux ----------------
	always_comb begin
		off      = paddr_i[7:0];
		inst_hit = (paddr_i[11:8] == INST_BASE[11:8]) && (paddr_i[1:0] == 2'b00);
		mapped   = 1'b1;
		rdata_c  = 32'h0000_0000;
		tx_hit   = 1'b0;
		tx_b     = 2'd0;
		tx_w     = 4'd0;
		rx_w     = 4'((off - `CMBM_RX_FOREGROUND_BUFFER_OFS) >> 2);
		case (off)
			`CMBM_CTRL_OFS: rdata_c[`CMBM_CTRL_LOOP] = loop_q;
			`CMBM_RFLG_OFS: rdata_c[1:0] = {ovr_q, rxf_q};
			`CMBM_RIER_OFS: rdata_c[1:0] = {ovrie_q, rxfie_q};
			`CMBM_TFLG_OFS: rdata_c[6:0] = {abort_acknowledge_flag_v, 1'b0, txe_v};
			`CMBM_TCTR_OFS: rdata_c[6:0] = {txeie_q, 1'b0, abort_request_flag_v};
			`CMBM_PCTL_OFS: rdata_c[`CMBM_PCTL_PULL] = pull_q;
			`CMBM_PDDR_OFS: rdata_c[7:0] = {ddr_q[7:2], 2'b10};
			`CMBM_PDAT_OFS: rdata_c[7:0] = port_pin_i;
			default: begin
				mapped = 1'b0;
				// Host only ever sees the foreground stage
				if (off >= `CMBM_RX_FOREGROUND_BUFFER_OFS && off < `CMBM_RX_FOREGROUND_BUFFER_END) begin
					mapped  = 1'b1;
					rdata_c = {24'h00_0000, rx_fg_q.bytes[rx_w]};
				end
				for (int b = 0; b < `CMBM_NUM_TXB; b++) begin
					if (off >= 8'(`CMBM_TXB0_OFS + b * `CMBM_TXB_STRIDE) &&
						{1'b0, off} < 9'(`CMBM_TXB0_OFS + (b + 1) * `CMBM_TXB_STRIDE)) begin
						tx_hit = 1'b1;
						tx_b   = 2'(b);
						tx_w   = 4'((off - 8'(`CMBM_TXB0_OFS + b * `CMBM_TXB_STRIDE)) >> 2);
						mapped = 1'b1;
						if (tx_w == `CMBM_LOCAL_PRIORITY_FIELD_IDX) begin
							rdata_c = {24'h00_0000, local_priority_field_q[b]};
						end else begin
							rdata_c = {24'h00_0000, tx_buf_q[b].bytes[tx_w]};
						end
					end
				end
			end
		endcase
	end

	assign wr_en = psel_i && penable_i && pready_q && pwrite_i && inst_hit && mapped;

	// Answer one cycle after setup, so data can come from a flop
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel_i && !penable_i;
			pslverr_q <= psel_i && !penable_i && !(inst_hit && mapped);
			if (psel_i && !penable_i) begin
				prdata_q <= (inst_hit && mapped && !pwrite_i) ? rdata_c : 32'h0000_0000;
			end
		end
	end

	// ---------------- Configuration and port ----------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			loop_q  <= 1'b0;
			pull_q  <= 1'b0;
			ddr_q   <= `CMBM_REG8_RST;
			pdat_q  <= `CMBM_REG8_RST;
			rxfie_q <= 1'b0;
			ovrie_q <= 1'b0;
			txeie_q <= 3'b000;
		end else if (wr_en) begin
			case (off)
				`CMBM_CTRL_OFS: loop_q <= pwdata_i[`CMBM_CTRL_LOOP];
				`CMBM_RIER_OFS: {ovrie_q, rxfie_q} <= pwdata_i[1:0];
				`CMBM_TCTR_OFS: txeie_q <= pwdata_i[`CMBM_TCTR_TXEIE +: 3];
				`CMBM_PCTL_OFS: pull_q <= pwdata_i[`CMBM_PCTL_PULL];
				`CMBM_PDDR_OFS: ddr_q <= pwdata_i[7:0];
				`CMBM_PDAT_OFS: pdat_q <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_out_q <= 8'hFF;
			oe_n_q    <= 8'hFF;
			bus_rx_q  <= 1'b1;
		end else begin
			// Bit 0 only listens, bit 1 drives the bus level from the first clock after reset
			pin_out_q <= {pdat_q[7:2], tx_bit_i, 1'b1};
			oe_n_q    <= {~ddr_q[7:2], 1'b0, 1'b1};
			bus_rx_q  <= port_pin_i[`CMBM_PORT_RX_BIT];
		end
	end

	// ---------------- Receive path ----------------
	assign own_frame = rx_evt_i.self_sent && !loop_q;
	assign accepted  = rx_evt_i.done && rx_evt_i.accept && !own_frame;
	assign rxf_clr   = wr_en && (off == `CMBM_RFLG_OFS) && pwdata_i[`CMBM_RFLG_RXF];

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rxf_q     <= 1'b0;
			bg_held_q <= 1'b0;
			rx_fg_q   <= '0;
			rx_bg_q   <= '0;
		end else begin
			// Background is frozen only while it holds an unread accepted frame
			if (rx_evt_i.done && !bg_held_q) begin
				rx_bg_q <= rx_evt_i.frame;
			end
			// A held frame refills the foreground, so the flag persists
			if (rxf_clr && rxf_q && !(accepted && !bg_held_q)) begin
				if (bg_held_q) begin
					rx_fg_q   <= rx_bg_q;
					bg_held_q <= 1'b0;
				end else begin
					rxf_q <= 1'b0;
				end
			end
			if (accepted) begin
				if (!rxf_q) begin
					rx_fg_q <= rx_evt_i.frame;
					rxf_q   <= 1'b1;
				end else if (!bg_held_q) begin
					if (rxf_clr) begin
						rx_fg_q <= rx_evt_i.frame;
					end else begin
						bg_held_q <= 1'b1;
					end
				end
			end
		end
	end

	// Overrun sticky flag, event beats a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ovr_q <= 1'b0;
		end else if (accepted && rxf_q && bg_held_q) begin
			ovr_q <= 1'b1;
		end else if (wr_en && off == `CMBM_RFLG_OFS && pwdata_i[`CMBM_RFLG_OVR]) begin
			ovr_q <= 1'b0;
		end
	end

	// ---------------- Transmit buffers ----------------
	generate
		for (genvar gb = 0; gb < `CMBM_NUM_TXB; gb++) begin : g_txb
			logic done_ok;
			logic abort_ok;
			assign done_ok  = tx_evt_i.ok && st_q == CMBM_TX_ON_BUS && act_q == 2'(gb);
			assign abort_ok = abort_request_flag_q[gb] && !txe_q[gb] &&
				!(st_q == CMBM_TX_ON_BUS && act_q == 2'(gb));
			assign txe_v[gb]   = txe_q[gb];
			assign abort_acknowledge_flag_v[gb] = abort_acknowledge_flag_q[gb];
			assign abort_request_flag_v[gb] = abort_request_flag_q[gb];

			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					txe_q[gb]   <= 1'b1;
					abort_acknowledge_flag_q[gb] <= 1'b0;
					abort_request_flag_q[gb] <= 1'b0;
				end else if (done_ok) begin
					txe_q[gb]   <= 1'b1;
					abort_acknowledge_flag_q[gb] <= 1'b0;
					abort_request_flag_q[gb] <= 1'b0;
				end else if (abort_ok) begin
					txe_q[gb]   <= 1'b1;
					abort_acknowledge_flag_q[gb] <= 1'b1;
					abort_request_flag_q[gb] <= 1'b0;
				end else begin
					if (wr_en && off == `CMBM_TFLG_OFS && pwdata_i[gb] && txe_q[gb]) begin
						txe_q[gb]   <= 1'b0;
						abort_acknowledge_flag_q[gb] <= 1'b0;
					end
					if (wr_en && off == `CMBM_TCTR_OFS && pwdata_i[gb] && !txe_q[gb]) begin
						abort_request_flag_q[gb] <= 1'b1;
					end
				end
			end

			// Contents are locked while the buffer is scheduled
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					tx_buf_q[gb] <= '0;
					local_priority_field_q[gb]   <= `CMBM_LOCAL_PRIORITY_FIELD_RST;
				end else if (wr_en && tx_hit && tx_b == 2'(gb) && txe_q[gb]) begin
					if (tx_w == `CMBM_LOCAL_PRIORITY_FIELD_IDX) begin
						local_priority_field_q[gb] <= pwdata_i[7:0];
					end else begin
						tx_buf_q[gb].bytes[tx_w] <= pwdata_i[7:0];
					end
				end
			end
		end
	endgenerate

	// Lowest value wins; ties go to the lowest buffer index
	always_comb begin
		best_ok   = 1'b0;
		best_idx  = 2'd0;
		best_local_priority_field = 8'hFF;
		for (int b = 0; b < `CMBM_NUM_TXB; b++) begin
			// A buffer awaiting its abort is not offered, so grant and pick never collide
			if (!txe_q[b] && !abort_request_flag_q[b] && (!best_ok || local_priority_field_q[b] < best_local_priority_field)) begin
				best_ok   = 1'b1;
				best_idx  = 2'(b);
				best_local_priority_field = local_priority_field_q[b];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q       <= CMBM_TX_IDLE;
			act_q      <= 2'd0;
			tx_frame_q <= '0;
		end else begin
			case (st_q)
				CMBM_TX_IDLE: begin
					// Fresh pick at each attempt, retries included
					if (tx_evt_i.arb_start && best_ok) begin
						st_q       <= CMBM_TX_ON_BUS;
						act_q      <= best_idx;
						tx_frame_q <= tx_buf_q[best_idx];
					end
				end
				CMBM_TX_ON_BUS: begin
					if (tx_evt_i.ok || tx_evt_i.err || tx_evt_i.lost) begin
						st_q <= CMBM_TX_IDLE;
					end
				end
				default: st_q <= CMBM_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_pend_q <= 1'b0;
			rx_irq_q  <= 1'b0;
			tx_irq_q  <= 1'b0;
			err_irq_q <= 1'b0;
		end else begin
			tx_pend_q <= best_ok;
			rx_irq_q  <= rxf_q && rxfie_q;
			tx_irq_q  <= |(txe_v & txeie_q);
			err_irq_q <= ovr_q && ovrie_q;
		end
	end

	assign prdata_o     = prdata_q;
	assign pready_o     = pready_q;
	assign pslverr_o    = pslverr_q;
	assign port_pin_o   = pin_out_q;
	assign port_oe_n_o  = oe_n_q;
	assign port_pull_o  = pull_q;
	assign bus_rx_pin_o = bus_rx_q;
	assign loopback_o   = loop_q;
	assign tx_pend_o    = tx_pend_q;
	assign tx_idx_o     = act_q;
	assign tx_frame_o   = tx_frame_q;
	assign rx_irq_o     = rx_irq_q;
	assign tx_irq_o     = tx_irq_q;
	assign err_irq_o    = err_irq_q;

	// ---------------- Assertions ----------------
	property p_rx_copy;
		@(posedge clk_i) disable iff (sys_rst_i)
		accepted && !rxf_q |=> rxf_q && rx_fg_q == $past(rx_evt_i.frame);
	endproperty
	a_rx_copy: assert property (p_rx_copy) else $error("accepted frame not copied");

	property p_rx_irq;
		@(posedge clk_i) disable iff (sys_rst_i)
		accepted && !rxf_q && rxfie_q && !(wr_en && off == `CMBM_RIER_OFS) |=> ##1 rx_irq_o;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt late");

	property p_overrun;
		@(posedge clk_i) disable iff (sys_rst_i)
		accepted && rxf_q && bg_held_q |=> ovr_q && $stable(rx_bg_q);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not handled");

	property p_own;
		@(posedge clk_i) disable iff (sys_rst_i)
		rx_evt_i.done && rx_evt_i.self_sent && !loop_q && !rxf_q && !bg_held_q
			|=> !rxf_q && rx_bg_q == $past(rx_evt_i.frame);
	endproperty
	a_own: assert property (p_own) else $error("own frame reached foreground");

	property p_tx_ok;
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_evt_i.ok && st_q == CMBM_TX_ON_BUS |=> txe_v[act_q] && !abort_acknowledge_flag_v[act_q] &&
			!abort_request_flag_v[act_q] && st_q == CMBM_TX_IDLE;
	endproperty
	a_tx_ok: assert property (p_tx_ok) else $error("success not released");

	property p_local_priority_field;
		@(posedge clk_i) disable iff (sys_rst_i)
		st_q == CMBM_TX_IDLE && tx_evt_i.arb_start && best_ok |=>
			st_q == CMBM_TX_ON_BUS &&
			($past(txe_q[0] || abort_request_flag_q[0]) || local_priority_field_q[act_q] <= $past(local_priority_field_q[0])) &&
			($past(txe_q[1] || abort_request_flag_q[1]) || local_priority_field_q[act_q] <= $past(local_priority_field_q[1])) &&
			($past(txe_q[2] || abort_request_flag_q[2]) || local_priority_field_q[act_q] <= $past(local_priority_field_q[2]));
	endproperty
	a_local_priority_field: assert property (p_local_priority_field) else $error("wrong buffer chosen");

	property p_no_abort_on_bus;
		@(posedge clk_i) disable iff (sys_rst_i)
		st_q == CMBM_TX_ON_BUS && abort_request_flag_v[act_q] && !tx_evt_i.ok |=> !abort_acknowledge_flag_v[$past(act_q)];
	endproperty
	a_no_abort_on_bus: assert property (p_no_abort_on_bus) else $error("frame on bus aborted");

	property p_abort_ack;
		@(posedge clk_i) disable iff (sys_rst_i)
		(abort_acknowledge_flag_v & ~$past(abort_acknowledge_flag_v) & ~(txe_v & ~abort_request_flag_v & $past(abort_request_flag_v))) == 3'b000;
	endproperty
	a_abort_ack: assert property (p_abort_ack) else $error("abort ack without request");

	property p_txe_clears_req;
		@(posedge clk_i) disable iff (sys_rst_i)
		(txe_v & ~$past(txe_v) & abort_request_flag_v) == 3'b000;
	endproperty
	a_txe_clears_req: assert property (p_txe_clears_req) else $error("stale abort request");

	property p_tx_pin;
		@(posedge clk_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> port_pin_o[`CMBM_PORT_TX_BIT] == $past(tx_bit_i) &&
			!port_oe_n_o[`CMBM_PORT_TX_BIT];
	endproperty
	a_tx_pin: assert property (p_tx_pin) else $error("transmit pin mismatch");

endmodule

// ===== include/cmbm_defines.svh
`ifndef CMBM_DEFINES_SVH
`define CMBM_DEFINES_SVH

// Byte offsets inside one instance window
`define CMBM_CTRL_OFS     8'h00
`define CMBM_RFLG_OFS     8'h04
`define CMBM_RIER_OFS     8'h08
`define CMBM_TFLG_OFS     8'h0C
`define CMBM_TCTR_OFS     8'h10
`define CMBM_PCTL_OFS     8'h14
`define CMBM_PDDR_OFS     8'h18
`define CMBM_PDAT_OFS     8'h1C
`define CMBM_RX_FOREGROUND_BUFFER_OFS     8'h20
`define CMBM_RX_FOREGROUND_BUFFER_END     8'h54
`define CMBM_TXB0_OFS     8'h58
`define CMBM_TXB_STRIDE   8'h38
`define CMBM_LOCAL_PRIORITY_FIELD_IDX     4'hD

// Instance placement
`define CMBM_INST1_OFS    12'h200
`define CMBM_INST2_OFS    12'h100

// Field positions
`define CMBM_FRAME_BYTES  13
`define CMBM_NUM_TXB      3
`define CMBM_CTRL_LOOP    0
`define CMBM_RFLG_RXF     0
`define CMBM_RFLG_OVR     1
`define CMBM_TFLG_ABORT_ACKNOWLEDGE_FLAG   4
`define CMBM_TCTR_TXEIE   4
`define CMBM_PCTL_PULL    0
`define CMBM_PORT_RX_BIT  0
`define CMBM_PORT_TX_BIT  1

// Reset values
`define CMBM_LOCAL_PRIORITY_FIELD_RST     8'h00
`define CMBM_REG8_RST     8'h00

`endif

// ===== include/cmbm_pkg.sv
`include "cmbm_defines.svh"

package cmbm_pkg;

	typedef struct packed {
		logic [`CMBM_FRAME_BYTES-1:0][7:0] bytes;
	} cmbm_frame_t;

	typedef struct packed {
		logic        done;
		logic        accept;
		logic        self_sent;
		cmbm_frame_t frame;
	} cmbm_rx_evt_t;

	typedef struct packed {
		logic arb_start;
		logic ok;
		logic err;
		logic lost;
	} cmbm_tx_evt_t;

	typedef enum {
		CMBM_TX_IDLE,
		CMBM_TX_ON_BUS
	} cmbm_txst_t;

endpackage

// ===== bench/cmbm_engine_model.sv
`timescale 1ns/1ps

module cmbm_engine_model
	import cmbm_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   tx_pend_i,
	input  wire logic   [7:0] pin_drv_i,
	input  wire logic   [7:0] pin_oe_n_i,
	input  wire logic   pull_i,
	output logic        [7:0] pin_lvl_o,
	output logic        tx_bit_o,
	output cmbm_rx_evt_t rx_evt_o,
	output cmbm_tx_evt_t tx_evt_o
);
	logic [7:0] float_q = 8'h55;

	initial begin
		tx_bit_o = 1'b1;
		rx_evt_o = '0;
		tx_evt_o = '0;
	end

	// Floating pins toggle so a stale level never passes for a driven one
	always @(posedge clk_i) begin
		float_q <= ~float_q;
	end

	always_comb begin
		for (int i = 1; i < 8; i++) begin
			pin_lvl_o[i] = !pin_oe_n_i[i] ? pin_drv_i[i] : (pull_i ? 1'b1 : float_q[i]);
		end
		// Lone node: bus is dominant only while our transmit pin drives low
		pin_lvl_o[0] = (!pin_oe_n_i[1] && !pin_drv_i[1]) ? 1'b0 : 1'b1;
	end

	task automatic drive_bit(input logic b);
		@(posedge clk_i);
		tx_bit_o <= b;
	endtask

	task automatic rx(input logic acc, input logic own, input cmbm_frame_t f);
		@(posedge clk_i);
		rx_evt_o <= '{1'b1, acc, own, f};
		@(posedge clk_i);
		rx_evt_o <= '0;
	endtask

	// Event codes: 0 arbitration start, 1 success, 2 error, 3 lost
	task automatic ev(input int k);
		@(posedge clk_i);
		tx_evt_o <= cmbm_tx_evt_t'(4'b1000 >> k);
		@(posedge clk_i);
		tx_evt_o <= '0;
	endtask

	task automatic arb();
		int n;
		n = 0;
		while (tx_pend_i !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		ev(0);
	endtask
endmodule

// ===== bench/can_message_buffer_manager_bench.sv
`timescale 1ns/1ps
`include "cmbm_defines.svh"

module can_message_buffer_manager_bench
	import cmbm_pkg::*;
;
	localparam logic [11:0] A_CTRL = {4'h0, `CMBM_CTRL_OFS};
	localparam logic [11:0] A_RFLG = {4'h0, `CMBM_RFLG_OFS};
	localparam logic [11:0] A_RIER = {4'h0, `CMBM_RIER_OFS};
	localparam logic [11:0] A_TFLG = {4'h0, `CMBM_TFLG_OFS};
	localparam logic [11:0] A_TCTR = {4'h0, `CMBM_TCTR_OFS};
	localparam logic [11:0] A_PCTL = {4'h0, `CMBM_PCTL_OFS};
	localparam logic [11:0] A_PDDR = {4'h0, `CMBM_PDDR_OFS};
	localparam logic [11:0] A_PDAT = {4'h0, `CMBM_PDAT_OFS};
	localparam logic [11:0] A_RX_FOREGROUND_BUFFER = {4'h0, `CMBM_RX_FOREGROUND_BUFFER_OFS};

	logic         clk_i = 1'b0;
	logic         sys_rst_i = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic  [11:0] paddr = 12'h000;
	logic  [31:0] pwdata = 32'h0000_0000;
	logic  [31:0] prdata;
	logic         pready, pslverr, pull, tx_bit, loopback, tx_pend;
	logic         rx_irq, tx_irq, err_irq, bus_rx;
	logic  [7:0]  pin_lvl, pin_drv, pin_oe_n;
	logic  [1:0]  tx_idx;
	cmbm_frame_t  tx_frame;
	cmbm_rx_evt_t rx_evt;
	cmbm_tx_evt_t tx_evt;
	int           err_count = 0;
	int           check_count = 0;
	integer       seed = 32'h9eaf_eb9f;
	logic  [31:0] rd;
	logic         er;
	logic  [2:0]  pend;
	cmbm_frame_t  f [4];
	cmbm_frame_t  txf [3];
	logic  [7:0]  local_priority_field [3];

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	cmbm_top #(.INSTANCE(0)) i_cmbm_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.port_pin_i(pin_lvl), .port_pin_o(pin_drv), .port_oe_n_o(pin_oe_n),
		.port_pull_o(pull), .bus_rx_pin_o(bus_rx), .tx_bit_i(tx_bit), .rx_evt_i(rx_evt),
		.tx_evt_i(tx_evt), .loopback_o(loopback), .tx_pend_o(tx_pend), .tx_idx_o(tx_idx),
		.tx_frame_o(tx_frame), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq), .err_irq_o(err_irq));

	cmbm_engine_model i_cmbm_engine_model (.clk_i(clk_i), .tx_pend_i(tx_pend),
		.pin_drv_i(pin_drv), .pin_oe_n_i(pin_oe_n), .pull_i(pull), .pin_lvl_o(pin_lvl),
		.tx_bit_o(tx_bit), .rx_evt_o(rx_evt), .tx_evt_o(tx_evt));

	task automatic stop_test();
		$display("errors=%0d checks=%0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [103:0] got, input logic [103:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// The slave answers in its own time; only the watchdog stops a hung wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdx(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic rdfg(input cmbm_frame_t x);
		for (int i = 0; i < 13; i++) begin
			rdx(A_RX_FOREGROUND_BUFFER + 12'(i * 4), {24'h00_0000, x.bytes[i]});
		end
	endtask

	function automatic logic [11:0] txa(input int b, input int i);
		return 12'(`CMBM_TXB0_OFS) + 12'(b) * 12'(`CMBM_TXB_STRIDE) + 12'(i * 4);
	endfunction

	function automatic logic [1:0] exp_sel(input logic [2:0] pm);
		logic [1:0] s;
		logic [8:0] best;
		s = 2'd0;
		best = 9'h100;
		for (int b = 0; b < 3; b++) begin
			if (pm[b] && {1'b0, local_priority_field[b]} < best) begin
				best = {1'b0, local_priority_field[b]};
				s = 2'(b);
			end
		end
		return s;
	endfunction

	// Host fills the whole buffer before it marks it ready
	task automatic load(input int b, input logic [7:0] p);
		local_priority_field[b] = p;
		for (int i = 0; i < 13; i++) begin
			txf[b].bytes[i] = 8'($random(seed));
			wr(txa(b, i), {24'h00_0000, txf[b].bytes[i]});
		end
		wr(txa(b, 13), {24'h00_0000, p});
	endtask

	task automatic send(input int res);
		logic [1:0] s;
		s = exp_sel(pend);
		i_cmbm_engine_model.arb();
		cyc(2);
		chk(tx_idx, s);
		chk(tx_frame, txf[s]);
		i_cmbm_engine_model.ev(res);
		if (res == 1) pend[s] = 1'b0;
		cyc(3);
		chk(tx_pend, |pend);
	endtask

	initial begin
		cyc(60000);
		err_count++;
		stop_test();
	end

	initial begin
		cyc(20);
		sys_rst_i <= 1'b0;
		rdx(A_TFLG, 32'h0000_0007);
		chk(er, 1'b0);
		rdx(A_RFLG, 32'h0000_0000);
		chk(pin_drv, 8'h03);
		chk(pin_oe_n, 8'hFD);
		apb(1'b0, 12'h200, 32'h0000_0000);
		chk(er, 1'b1);
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk(er, 1'b1);
		wr(A_PDDR, 32'h0000_00FC);
		wr(A_PDAT, 32'h0000_00A8);
		cyc(2);
		chk(pin_oe_n, 8'h01);
		chk(pin_drv[7:2], 6'h2A);
		i_cmbm_engine_model.drive_bit(1'b0);
		cyc(3);
		chk(pin_drv[1], 1'b0);
		chk(bus_rx, 1'b0);
		i_cmbm_engine_model.drive_bit(1'b1);
		cyc(3);
		rdx(A_PDAT, 32'h0000_00AB);
		rdx(A_PDDR, 32'h0000_00FE);
		wr(A_PCTL, 32'h0000_0001);
		wr(A_PDDR, 32'h0000_0000);
		cyc(2);
		chk(pull, 1'b1);
		rdx(A_PDAT, 32'h0000_00FF);
		for (int k = 0; k < 4; k++) begin
			f[k] = 104'({$random(seed), $random(seed), $random(seed), $random(seed)});
		end
		wr(A_RIER, 32'h0000_0003);
		i_cmbm_engine_model.rx(1'b1, 1'b0, f[0]);
		cyc(2);
		chk(rx_irq, 1'b1);
		rdx(A_RFLG, 32'h0000_0001);
		rdfg(f[0]);
		i_cmbm_engine_model.rx(1'b0, 1'b0, f[1]);
		i_cmbm_engine_model.rx(1'b1, 1'b0, f[2]);
		i_cmbm_engine_model.rx(1'b1, 1'b0, f[3]);
		cyc(2);
		rdx(A_RFLG, 32'h0000_0003);
		chk(err_irq, 1'b1);
		rdfg(f[0]);
		wr(A_RFLG, 32'h0000_0002);
		rdx(A_RFLG, 32'h0000_0001);
		wr(A_RFLG, 32'h0000_0001);
		rdx(A_RFLG, 32'h0000_0001);
		rdfg(f[2]);
		wr(A_RFLG, 32'h0000_0001);
		cyc(2);
		rdx(A_RFLG, 32'h0000_0000);
		chk(rx_irq, 1'b0);
		i_cmbm_engine_model.rx(1'b1, 1'b1, f[1]);
		cyc(2);
		rdx(A_RFLG, 32'h0000_0000);
		wr(A_CTRL, 32'h0000_0001);
		cyc(1);
		chk(loopback, 1'b1);
		i_cmbm_engine_model.rx(1'b1, 1'b1, f[3]);
		cyc(2);
		rdx(A_RFLG, 32'h0000_0001);
		rdfg(f[3]);
		wr(A_RFLG, 32'h0000_0001);
		wr(A_TCTR, 32'h0000_0070);
		cyc(3);
		chk(tx_irq, 1'b1);
		load(0, 8'($random(seed)));
		local_priority_field[1] = 8'($random(seed));
		load(1, local_priority_field[1]);
		load(2, local_priority_field[1]);
		wr(A_TFLG, 32'h0000_0007);
		cyc(3);
		rdx(A_TFLG, 32'h0000_0000);
		chk(tx_irq, 1'b0);
		pend = 3'b111;
		for (int k = 0; k < 3; k++) begin
			send(1);
		end
		rdx(A_TFLG, 32'h0000_0007);
		chk(tx_irq, 1'b1);
		load(0, 8'h80);
		wr(A_TFLG, 32'h0000_0001);
		pend = 3'b001;
		send(2);
		load(1, 8'h10);
		wr(A_TFLG, 32'h0000_0002);
		pend = 3'b011;
		send(3);
		send(1);
		send(1);
		load(2, 8'h00);
		wr(A_TFLG, 32'h0000_0004);
		cyc(2);
		wr(A_TCTR, 32'h0000_0074);
		cyc(2);
		rdx(A_TFLG, 32'h0000_0047);
		rdx(A_TCTR, 32'h0000_0070);
		load(0, 8'h05);
		wr(A_TFLG, 32'h0000_0001);
		i_cmbm_engine_model.arb();
		cyc(2);
		wr(A_TCTR, 32'h0000_0071);
		cyc(2);
		rdx(A_TFLG, 32'h0000_0046);
		i_cmbm_engine_model.ev(1);
		cyc(3);
		rdx(A_TFLG, 32'h0000_0047);
		rdx(A_TCTR, 32'h0000_0070);
		stop_test();
	end
endmodule
